// File: hdl/opp_port.sv
`timescale 1ns/1ps
// PROM-mode parallel programming port.
module opp_port (
   // Clock and reset.
   input  wire logic                       clk_sys,
   input  wire logic                       rst,
   // Mode strap.
   input  wire logic                       prom_mode,
   // Address pins.
   input  wire logic                       top_addr_bit,
   input  wire logic [7:0]                 mid_addr_byte,
   input  wire logic [7:0]                 low_addr_byte,
   // Data pins.
   input  wire logic [opp_pkg::DATA_W-1:0] prom_data_bus_i,
   output logic [opp_pkg::DATA_W-1:0]      prom_data_bus_o,
   output logic                            prom_data_bus_oe,
   // Strobes, active low.
   input  wire logic                       chip_en_n,
   input  wire logic                       out_en_n,
   input  wire logic                       write_pulse_in_n,
   // Status.
   output logic                            write_busy
);
   import opp_pkg::*;

   // ----------------------------------------------------------------
   // Address and pulse capture
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0]  addr;
   logic               in_range;
   logic               sel;
   opp_state_type      st_q, st_d;
   logic [19:0]        cnt_q, cnt_d;
   logic               fifo_valid, fifo_ready;
   logic               wq_valid, wq_ready;
   logic [ARRAY_W+DATA_W-1:0] wq_data;
   logic [DATA_W-1:0]  rd_data;
   logic               oe_q, oe_d;
   logic [DATA_W-1:0]  dout_q, dout_d;
   logic [19:0]        low_run_q, low_run_d;

   // Address formed from the three pin groups; top bits must be zero.
   always_comb begin
      addr     = {top_addr_bit, mid_addr_byte, low_addr_byte};
      in_range = (addr[ADDR_W-1:ARRAY_W] == '0);
      sel      = prom_mode && !chip_en_n;
   end

   // Pulse timer: a low pulse of at least the programming time queues one write for an in-range address.
   always_comb begin
      st_d       = st_q;
      cnt_d      = cnt_q;
      fifo_valid = 1'b0;
      case (st_q)
         OPP_IDLE: begin
            cnt_d = '0;
            if (sel && !write_pulse_in_n) begin
               st_d = OPP_PULSE;
            end
         end
         OPP_PULSE: begin
            if (!sel || write_pulse_in_n) begin
               st_d = OPP_IDLE;
            end else if (cnt_q == 20'(PULSE_CYC - 2)) begin
               fifo_valid = in_range;
               if (fifo_ready || !in_range) begin
                  st_d = OPP_DONE;
               end
            end else begin
               cnt_d = cnt_q + 20'h00001;
            end
         end
         OPP_DONE: begin
            if (!sel || write_pulse_in_n) begin
               st_d = OPP_IDLE;
            end
         end
         default: st_d = OPP_IDLE;
      endcase
   end

   // Pulse timer registers.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q  <= OPP_IDLE;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Strobe-width monitor
   // ----------------------------------------------------------------
   // Counts the clocks of the current low program strobe, saturating at the top.
   always_comb begin
      if (!sel || write_pulse_in_n) begin
         low_run_d = 20'h00000;
      end else if (low_run_q == 20'hFFFFF) begin
         low_run_d = low_run_q;
      end else begin
         low_run_d = low_run_q + 20'h00001;
      end
   end

   // Strobe-width register; it only feeds the pulse-width check.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         low_run_q <= 20'h00000;
      end else begin
         low_run_q <= low_run_d;
      end
   end

   // ----------------------------------------------------------------
   // Write queue and array
   // ----------------------------------------------------------------
   opp_fifo #(.WIDTH(ARRAY_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (fifo_valid),
      .in_ready  (fifo_ready),
      .in_data   ({addr[ARRAY_W-1:0], prom_data_bus_i}),
      .out_valid (wq_valid),
      .out_ready (wq_ready),
      .out_data  (wq_data)
   );

   // Array takes one write per clock; queue drains freely.
   assign wq_ready   = 1'b1;
   assign write_busy = wq_valid || (st_q == OPP_PULSE);

   opp_mem u_mem (
      .clk_sys (clk_sys),
      .wr_en   (wq_valid && wq_ready),
      .wr_addr (wq_data[ARRAY_W+DATA_W-1:DATA_W]),
      .wr_data (wq_data[DATA_W-1:0]),
      .rd_addr (addr[ARRAY_W-1:0]),
      .rd_data (rd_data)
   );

   // ----------------------------------------------------------------
   // Verify read drive
   // ----------------------------------------------------------------
   // Bus driven for any read, in range or not (out of range reads all ones); no signature mode exists.
   always_comb begin
      oe_d   = sel && !out_en_n && write_pulse_in_n;
      dout_d = in_range ? rd_data : ERASED_BYTE;
   end

   // Enable and data are registered so the pins never glitch.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         oe_q   <= 1'b0;
         dout_q <= 8'h00;
      end else begin
         oe_q   <= oe_d;
         dout_q <= dout_d;
      end
   end

   assign prom_data_bus_o  = dout_q;
   assign prom_data_bus_oe = oe_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Output enable follows a clean read request and nothing else, one clock late.
   chk_oe_needs_read: assert property (@(posedge clk_sys) disable iff (rst)
      prom_data_bus_oe |-> $past(sel && !out_en_n && write_pulse_in_n))
      else $error("data bus driven outside a read");

   chk_oe_follows: assert property (@(posedge clk_sys) disable iff (rst)
      (sel && !out_en_n && write_pulse_in_n) |=> prom_data_bus_oe)
      else $error("data bus not driven for a read");

   chk_pulse_no_oe: assert property (@(posedge clk_sys) disable iff (rst)
      $past(!write_pulse_in_n) |-> !prom_data_bus_oe)
      else $error("data bus driven during program pulse");

   // A write is queued only after the strobe has stayed low for the full pulse.
   chk_short_no_write: assert property (@(posedge clk_sys) disable iff (rst)
      fifo_valid |-> !write_pulse_in_n && low_run_q >= 20'(PULSE_CYC - 1))
      else $error("write queued before full pulse time");

   chk_fifo_space: assert property (@(posedge clk_sys) disable iff (rst)
      fifo_valid |-> fifo_ready)
      else $error("write queue full at end of pulse");

   chk_range_write: assert property (@(posedge clk_sys) disable iff (rst)
      fifo_valid |-> in_range)
      else $error("write queued for out-of-range address");

   // The queued entry carries the pins as they stood at the end of the pulse.
   chk_addr_form: assert property (@(posedge clk_sys) disable iff (rst)
      (fifo_valid && fifo_ready) |=> wq_valid
         && wq_data[ARRAY_W+DATA_W-1:DATA_W] == $past({mid_addr_byte[ARRAY_W-9:0], low_addr_byte}))
      else $error("queued address differs from the address pins");

   chk_write_data: assert property (@(posedge clk_sys) disable iff (rst)
      (fifo_valid && fifo_ready) |=> wq_data[DATA_W-1:0] == $past(prom_data_bus_i))
      else $error("queued data differs from the data pins");

   chk_strobe_gate: assert property (@(posedge clk_sys) disable iff (rst)
      (st_q == OPP_IDLE && (chip_en_n || !prom_mode)) |=> st_q == OPP_IDLE)
      else $error("pulse timer started without chip enable");

   chk_pulse_exit: assert property (@(posedge clk_sys) disable iff (rst)
      (st_q == OPP_PULSE && (!sel || write_pulse_in_n)) |=> st_q == OPP_IDLE)
      else $error("cut pulse did not return to idle");

   chk_state_onehot: assert property (@(posedge clk_sys) disable iff (rst)
      $onehot(st_q))
      else $error("pulse timer state not one-hot");

   chk_oor_erased: assert property (@(posedge clk_sys) disable iff (rst)
      !in_range |=> prom_data_bus_o == ERASED_BYTE)
      else $error("out-of-range read not all ones");

   chk_one_write: assert property (@(posedge clk_sys) disable iff (rst)
      (fifo_valid && fifo_ready) |=> st_q == OPP_DONE)
      else $error("more than one write per pulse");

   // ----------------------------------------------------------------
   // Coverage of the main scenarios
   // ----------------------------------------------------------------
   cov_write: cover property (@(posedge clk_sys) fifo_valid && fifo_ready);
   cov_read: cover property (@(posedge clk_sys) prom_data_bus_oe);
   cov_abort: cover property (@(posedge clk_sys) st_q == OPP_PULSE && write_pulse_in_n);
   cov_oor_write: cover property (@(posedge clk_sys) st_q == OPP_PULSE && cnt_q == 20'(PULSE_CYC - 2) && !in_range);
   cov_strap_off: cover property (@(posedge clk_sys) !prom_mode && !chip_en_n && !write_pulse_in_n);
endmodule : opp_port

// File: hdl/opp_pkg.sv
// Behaviour
// - Accept 17-bit address from three pin groups.
// - Bidirectional data bus: write in, verify out.
// - Chip enable, output enable, program strobes.
// - Low 0.1 ms pulse writes byte.
// - No identification read mode exists.
// - Array of 16K bytes, contiguous from zero.
package opp_pkg;
   localparam int unsigned ADDR_W      = 17;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ARRAY_W     = 14;
   localparam int unsigned ARRAY_DEPTH = 16384;
   localparam int unsigned CLK_MHZ     = 125;
   localparam int unsigned PULSE_NS    = 100000;
   localparam int unsigned PULSE_CYC   = (PULSE_NS * CLK_MHZ) / 1000;
   localparam int unsigned FIFO_DEPTH  = 4;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;

   typedef enum logic [2:0] {
      OPP_IDLE  = 3'b001,
      OPP_PULSE = 3'b010,
      OPP_DONE  = 3'b100
   } opp_state_type;
endpackage : opp_pkg

// File: hdl/opp_fifo.sv
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides.
module opp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset.
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [PW:0]      cnt_q, cnt_d;
   logic             push, pop;

   // Handshake and pointer updates.
   always_comb begin
      in_ready  = (cnt_q != (PW + 1)'(DEPTH));
      out_valid = (cnt_q != '0);
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wr_d      = push ? wr_q + 1'b1 : wr_q;
      rd_d      = pop ? rd_q + 1'b1 : rd_q;
      cnt_d     = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      out_data  = mem_q[rd_q];
   end

   // Pointer registers.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : opp_fifo

// File: hdl/opp_mem.sv
`timescale 1ns/1ps
// One-time-programmable array model: bits can only be cleared, reads registered.
module opp_mem (
   // Clock.
   input  wire logic                         clk_sys,
   // Write port.
   input  wire logic                         wr_en,
   input  wire logic [opp_pkg::ARRAY_W-1:0]  wr_addr,
   input  wire logic [opp_pkg::DATA_W-1:0]   wr_data,
   // Read port.
   input  wire logic [opp_pkg::ARRAY_W-1:0]  rd_addr,
   output logic [opp_pkg::DATA_W-1:0]        rd_data
);
   import opp_pkg::*;

   // Cells start erased, all ones; no reset can reach an array this large.
   logic [DATA_W-1:0] cell_q [ARRAY_DEPTH] = '{default: ERASED_BYTE};

   // Programming clears bits only; read data comes from a register.
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         cell_q[wr_addr] <= cell_q[wr_addr] & wr_data;
      end
      rd_data <= cell_q[rd_addr];
   end
endmodule : opp_mem

// File: tb/opp_prog.sv
`timescale 1ns/1ps
// Programmer model: changes pins just after a rising edge and holds them across each strobe.
module opp_prog (
   // Clock.
   input  wire logic        clk_sys,
   // Pins toward the port.
   output logic             prom_mode,
   output logic [16:0]      addr,
   output logic [7:0]       wdata,
   output logic             wdrive,
   output logic             chip_en_n,
   output logic             out_en_n,
   output logic             write_pulse_in_n,
   // Seen back from the port.
   input  wire logic [7:0]  bus,
   input  wire logic        write_busy
);
   import opp_pkg::*;
   // Run-mode image bases: the low region and the top page land in one block from zero.
   localparam logic [19:0] RUN_LOW_BASE  = 20'h04000;
   localparam logic [19:0] RUN_TOP_BASE  = 20'hFFF00;
   localparam logic [16:0] PROG_TOP_BASE = 17'h03F00;
   localparam logic [16:0] PROG_LAST     = 17'h03FFF;
   // Maps a run-mode address onto the contiguous programming range.
   function automatic logic [16:0] reloc(input logic [19:0] ra);
      logic [19:0] off;
      off = (ra >= RUN_TOP_BASE) ? ra - RUN_TOP_BASE : ra - RUN_LOW_BASE;
      reloc = (ra >= RUN_TOP_BASE) ? PROG_TOP_BASE + off[16:0] : off[16:0];
   endfunction : reloc
   // Strapped into PROM mode, strobes idle; no signature access is ever made.
   initial begin
      prom_mode = 1'b1;
      addr = '0;
      wdata = '0;
      wdrive = 1'b0;
      {chip_en_n, out_en_n, write_pulse_in_n} = 3'b111;
   end
   // Sets the strap and the three strobes together.
   task automatic pins(input logic [3:0] s);
      @(posedge clk_sys);
      {prom_mode, chip_en_n, out_en_n, write_pulse_in_n} <= s;
   endtask : pins
   // Low program strobe for n cycles with address and data held, then waits out busy.
   task automatic put(input logic [16:0] a, input logic [7:0] d, input int n);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wdrive <= 1'b1;
      chip_en_n <= 1'b0;
      write_pulse_in_n <= 1'b0;
      repeat (n) @(posedge clk_sys);
      {write_pulse_in_n, chip_en_n, wdrive} <= 3'b110;
      for (int i = 0; i < 64 && write_busy !== 1'b0; i++) @(negedge clk_sys);
   endtask : put
   // Verify read: strobes low, data taken once settled.
   task automatic get(input logic [16:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      {chip_en_n, out_en_n} <= 2'b00;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      d = bus;
      @(posedge clk_sys);
      {chip_en_n, out_en_n} <= 2'b11;
   endtask : get
   // Pulse and verify until the byte reads back, giving up after 25 pulses.
   task automatic prog(input logic [16:0] a, input logic [7:0] d, output int np);
      logic [7:0] r;
      np = 0;
      if (a <= PROG_LAST) begin
         do begin
            put(a, d, PULSE_CYC);
            np++;
            get(a, r);
         end while (r !== d && np < 25);
      end
   endtask : prog
   // Verify pass over the whole programming range, one address per clock;
   // every location but the programmed one is expected all ones.
   task automatic verify_all(input logic [16:0] pa, input logic [7:0] pd, output int nbad);
      logic [7:0] want;
      nbad = 0;
      for (int i = 0; i < ARRAY_DEPTH + 2; i++) begin
         @(posedge clk_sys);
         if (i < ARRAY_DEPTH) addr <= 17'(i);
         if (i == 0) {chip_en_n, out_en_n} <= 2'b00;
         if (i >= 2) begin
            @(negedge clk_sys);
            want = (17'(i - 2) == pa) ? pd : ERASED_BYTE;
            if (bus !== want) nbad++;
         end
      end
      @(posedge clk_sys);
      {chip_en_n, out_en_n} <= 2'b11;
   endtask : verify_all
endmodule : opp_prog

// File: tb/opp_port_tb_top.sv
`timescale 1ns/1ps
module opp_port_tb_top;
   import opp_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        pm, ce_n, oe_n, pg_n, wdrive, busy, dut_oe;
   logic [16:0] addr;
   logic [7:0]  wdata, dut_o, bus, r;
   int          bad_count = 0;
   int          n_tests = 0;
   int          np;
   // System clock.
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   // Data wire: port first, then programmer, else a level that keeps moving.
   assign bus = dut_oe ? dut_o : (wdrive ? wdata : (8'h5A ^ {8{clk_sys}}));
   opp_port u_opp_port (.clk_sys(clk_sys), .rst(rst), .prom_mode(pm), .top_addr_bit(addr[16]),
      .mid_addr_byte(addr[15:8]), .low_addr_byte(addr[7:0]), .prom_data_bus_i(bus),
      .prom_data_bus_o(dut_o), .prom_data_bus_oe(dut_oe), .chip_en_n(ce_n), .out_en_n(oe_n),
      .write_pulse_in_n(pg_n), .write_busy(busy));
   opp_prog u_opp_prog (.clk_sys(clk_sys), .prom_mode(pm), .addr(addr), .wdata(wdata), .wdrive(wdrive),
      .chip_en_n(ce_n), .out_en_n(oe_n), .write_pulse_in_n(pg_n), .bus(bus), .write_busy(busy));
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // Full pulse programs a byte in one go; its neighbour stays erased.
   task automatic t_prog;
      u_opp_prog.prog(u_opp_prog.reloc(20'hFFF5A), 8'hA5, np);
      chk("pulses", 8'h01, np[7:0]);
      chk("busy", 8'h00, {7'h00, busy});
      u_opp_prog.get(17'h03F5A, r);
      chk("rd 03F5A", 8'hA5, r);
      u_opp_prog.get(17'h03F5B, r);
      chk("rd 03F5B", ERASED_BYTE, r);
      $display("t_prog done");
   endtask : t_prog
   // A pulse far shorter than the full width writes nothing.
   task automatic t_short;
      u_opp_prog.put(u_opp_prog.reloc(20'h04020), 8'h00, 100);
      u_opp_prog.get(17'h00020, r);
      chk("short", ERASED_BYTE, r);
      $display("t_short done");
   endtask : t_short
   // A write above the array neither lands nor aliases onto low addresses.
   task automatic t_range;
      u_opp_prog.put(17'h14020, 8'h00, PULSE_CYC);
      u_opp_prog.get(17'h14020, r);
      chk("rd 14020", ERASED_BYTE, r);
      u_opp_prog.get(17'h00020, r);
      chk("alias 00020", ERASED_BYTE, r);
      $display("t_range done");
   endtask : t_range
   // A second pulse can only clear bits of a programmed byte.
   task automatic t_otp;
      u_opp_prog.put(17'h03F5A, 8'h3C, PULSE_CYC);
      u_opp_prog.get(17'h03F5A, r);
      chk("otp and", 8'h24, r);
      $display("t_otp done");
   endtask : t_otp
   // Every strap and strobe mix: only a clean read may drive the wire.
   task automatic t_gate;
      for (int s = 0; s < 16; s++) begin
         u_opp_prog.pins(s[3:0]);
         repeat (4) @(posedge clk_sys);
         @(negedge clk_sys);
         chk("oe", {7'h00, s == 9}, {7'h00, dut_oe});
         if (s == 9) chk("drv", 8'h24, bus);
      end
      u_opp_prog.pins(4'hF);
      $display("t_gate done");
   endtask : t_gate
   // Whole-range verify pass: the one programmed byte, every other location all ones.
   task automatic t_verify;
      int nbad;
      u_opp_prog.verify_all(u_opp_prog.reloc(20'hFFF5A), 8'h24, nbad);
      chk("verify pass", 8'h00, (nbad > 255) ? 8'hFF : nbad[7:0]);
      $display("t_verify done");
   endtask : t_verify
   // Cuts a hang short: the scenarios need about 55000 clocks, the limit is 90000.
   initial begin
      #720000;
      bad_count++;
      wrap_up();
   end
   // Reset, then the scenarios in order.
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      chk("oe rst", 8'h00, {7'h00, dut_oe});
      t_prog();
      t_short();
      t_range();
      t_otp();
      t_gate();
      t_verify();
      wrap_up();
   end
endmodule : opp_port_tb_top
